//--- logic/rpt_host.sv
// Host end: generates pixel clock, frame timing, data and reset
`timescale 1ns/1ns
`default_nettype none
`include "rpt_map.svh"
module rpt_host
  import rpt_pkg::*;
#(
  parameter int CMD_WAIT  = `RPT_CMD_WAIT_CYCLES,
  parameter int WAKE_WAIT = `RPT_WAKE_WAIT_CYCLES
)(
  input  wire logic        clock,         // System clock
  input  wire logic        reset_n,       // Async reset
  input  wire logic        clock_enable,  // Freeze when low
  input  wire logic        panel_reset,   // Pulse: reset the panel
  input  wire logic        pix_valid,     // Pixel word offered
  input  wire logic [23:0] pix_data,      // Pixel word
  output logic             pix_ready,     // Buffer has room
  output logic             cmd_allowed,   // Serial commands allowed
  output logic             wake_allowed,  // Low-power exit allowed
  rpt_link_if.host         link           // Panel link
);
  logic [3:0]    div_reg;
  logic          pclk_reg;
  logic          tick;
  rpt_phase_type hph_reg, vph_reg;
  logic [9:0]    hcnt_reg, vcnt_reg;
  logic          hs_reg, vs_reg, de_reg;
  logic [23:0]   pd_reg;
  logic [23:0]   buf_mem [2];
  logic          wr_reg, rd_reg;
  logic [1:0]    cnt_reg;
  logic          pop;
  logic [31:0]   rst_cnt_reg;
  logic          rst_out_reg;
  logic [31:0]   wait_reg;

  function automatic logic [9:0] phase_len(input rpt_phase_type p,
                                           input logic vert);
    if (p == RPT_SYNC)
      phase_len = vert ? {2'h0, `RPT_VSYNC_LOW_WIDTH}
                       : {2'h0, `RPT_HSYNC_LOW_WIDTH};
    else if (p == RPT_BACK)
      phase_len = vert ? {2'h0, `RPT_VERTICAL_BACK_PORCH}
                       : {2'h0, `RPT_H_BACK_PORCH};
    else if (p == RPT_ACTIVE)
      phase_len = vert ? `RPT_VERTICAL_ACTIVE : `RPT_HORIZONTAL_ACTIVE;
    else
      phase_len = vert ? {2'h0, `RPT_VERTICAL_FRONT_PORCH}
                       : {2'h0, `RPT_HORIZONTAL_FRONT_PORCH};
  endfunction

  // ==========================================================
  // Pixel clock divider
  // ==========================================================
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      div_reg  <= 4'h0;
      pclk_reg <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (div_reg == `RPT_HOST_DIV - 4'h1)
      begin
        div_reg  <= 4'h0;
        pclk_reg <= ~pclk_reg;
      end
      else
        div_reg <= div_reg + 4'h1;
    end
  assign tick = clock_enable && pclk_reg &&
                (div_reg == `RPT_HOST_DIV - 4'h1);

  // ==========================================================
  // Line and frame counters
  // ==========================================================
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      hph_reg  <= RPT_SYNC;
      vph_reg  <= RPT_SYNC;
      hcnt_reg <= 10'h0;
      vcnt_reg <= 10'h0;
    end
    else if (tick)
    begin
      if (hcnt_reg == phase_len(hph_reg, 1'b0) - 10'h1)
      begin
        hcnt_reg <= 10'h0;
        hph_reg  <= rpt_phase_type'(hph_reg + 2'h1);
        if (hph_reg == RPT_FRONT)
        begin
          if (vcnt_reg == phase_len(vph_reg, 1'b1) - 10'h1)
          begin
            vcnt_reg <= 10'h0;
            vph_reg  <= rpt_phase_type'(vph_reg + 2'h1);
          end
          else
            vcnt_reg <= vcnt_reg + 10'h1;
        end
      end
      else
        hcnt_reg <= hcnt_reg + 10'h1;
    end

  // ==========================================================
  // Two-entry pixel buffer
  // ==========================================================
  assign pop = tick && hph_reg == RPT_ACTIVE && vph_reg == RPT_ACTIVE &&
               cnt_reg != 2'h0;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else if (clock_enable)
    begin
      if (pix_valid && pix_ready)
        wr_reg <= ~wr_reg;
      if (pop)
        rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, pix_valid && pix_ready} - {1'b0, pop};
    end
  always_ff @(posedge clock)
    if (clock_enable && pix_valid && pix_ready)
      buf_mem[wr_reg] <= pix_data;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      pix_ready <= 1'b0;
    else if (clock_enable)
      pix_ready <= (cnt_reg + {1'b0, pix_valid && pix_ready}
                    - {1'b0, pop}) < 2'h2;

  // ==========================================================
  // Pin registers, updated on the falling pixel clock edge
  // ==========================================================
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      hs_reg <= 1'b1;
      vs_reg <= 1'b1;
      de_reg <= 1'b0;
      pd_reg <= 24'h0;
    end
    else if (tick)
    begin
      hs_reg <= hph_reg != RPT_SYNC;
      vs_reg <= vph_reg != RPT_SYNC;
      de_reg <= pop;
      pd_reg <= pop ? buf_mem[rd_reg] : 24'h0;
    end

  // ==========================================================
  // Panel reset pulse and post-release waits
  // ==========================================================
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      rst_cnt_reg <= 32'h0;
      rst_out_reg <= 1'b0;
      wait_reg    <= 32'h0;
      cmd_allowed  <= 1'b0;
      wake_allowed <= 1'b0;
    end
    else if (clock_enable)
    begin
      if (panel_reset && rst_out_reg)
      begin
        rst_out_reg <= 1'b0;
        rst_cnt_reg <= 32'h0;
      end
      else if (!rst_out_reg)
      begin
        if (rst_cnt_reg == `RPT_RESET_HOLD_CYCLES - 1)
          rst_out_reg <= 1'b1;
        else
          rst_cnt_reg <= rst_cnt_reg + 32'h1;
      end
      if (!rst_out_reg)
        wait_reg <= 32'h0;
      else if (wait_reg < WAKE_WAIT)
        wait_reg <= wait_reg + 32'h1;
      cmd_allowed  <= rst_out_reg && wait_reg >= CMD_WAIT;
      wake_allowed <= rst_out_reg && wait_reg >= WAKE_WAIT;
    end

  assign link.pixel_clock = pclk_reg;
  assign link.hsync_n     = hs_reg;
  assign link.vsync_n     = vs_reg;
  assign link.data_enable = de_reg;
  assign link.pixel_data  = pd_reg;
  assign link.reset_n     = rst_out_reg;
endmodule
`default_nettype wire

//--- logic/rpt_link_if.sv
// Pixel bus and reset wires between host and panel
`timescale 1ns/1ns
`default_nettype none
interface rpt_link_if;
  logic        pixel_clock;
  logic        hsync_n;
  logic        vsync_n;
  logic        data_enable;
  logic [23:0] pixel_data;
  logic        reset_n;
  modport host (output pixel_clock, hsync_n, vsync_n, data_enable,
                output pixel_data, reset_n);
  modport panel (input pixel_clock, hsync_n, vsync_n, data_enable,
                 input pixel_data, reset_n);
endinterface
`default_nettype wire

//--- logic/rpt_map.svh
// Timing constants for the RGB panel timing and reset link
`ifndef RPT_MAP_SVH
`define RPT_MAP_SVH
`define RPT_HSYNC_LOW_WIDTH        8'h04
`define RPT_H_BACK_PORCH           8'h08
`define RPT_HORIZONTAL_ACTIVE      10'h1e0
`define RPT_HORIZONTAL_FRONT_PORCH 8'h08
`define RPT_VSYNC_LOW_WIDTH        8'h02
`define RPT_VERTICAL_BACK_PORCH    8'h04
`define RPT_VERTICAL_ACTIVE        10'h356
`define RPT_VERTICAL_FRONT_PORCH   8'h04
`define RPT_HOST_DIV               4'h1
`define RPT_PIXEL_MHZ_X10          32'd240
`define RPT_SPIKE_REJECT_NS        32'd5000
`define RPT_RESET_ACCEPT_NS        32'd9000
`define RPT_RESET_LOW_MIN_NS       32'd10000
`define RPT_CMD_WAIT_US            32'd5000
`define RPT_WAKE_WAIT_US           32'd120000
`define RPT_CLOCK_MHZ              32'd20
`define RPT_FILTER_CYCLES (((`RPT_SPIKE_REJECT_NS+`RPT_RESET_ACCEPT_NS)/2*`RPT_PIXEL_MHZ_X10+9999)/10000)
`define RPT_RESET_HOLD_CYCLES ((`RPT_RESET_LOW_MIN_NS*`RPT_CLOCK_MHZ+999)/1000)
`define RPT_CMD_WAIT_CYCLES (`RPT_CMD_WAIT_US*`RPT_CLOCK_MHZ)
`define RPT_WAKE_WAIT_CYCLES (`RPT_WAKE_WAIT_US*`RPT_CLOCK_MHZ)
`define RPT_RELOAD_CYCLES 32'd2000
`endif

//--- logic/rpt_panel.sv
// Panel end: reset filter, blanking, reload and pixel capture
`timescale 1ns/1ns
`default_nettype none
`include "rpt_map.svh"
module rpt_panel
  import rpt_pkg::*;
#(
  parameter int FILTER = `RPT_FILTER_CYCLES,
  parameter int RELOAD = `RPT_RELOAD_CYCLES
)(
  input  wire logic        clock_enable,   // Freeze when low
  input  wire logic        power_reset_n,  // Async power-on reset
  input  wire logic        low_power,      // Panel in low-power state
  input  wire logic        pix_ready,      // Consumer takes pixel
  output logic             pix_valid,      // Pixel word available
  output logic [23:0]      pix_data,       // Pixel word
  output logic             blank,          // Display blanked
  output logic             in_reset,       // Reset in progress
  rpt_link_if.panel        link            // Host link
);
  logic       rs1_reg, rs2_reg, filt_reg;
  logic [15:0] fcnt_reg;
  rpt_dev_state_type st_reg;
  logic [31:0] tcnt_reg;
  logic [23:0] buf_mem [2];
  logic        wr_reg, rd_reg;
  logic [1:0]  cnt_reg;
  logic        push, pull;
  logic        lp1_reg, lp2_reg;

  // ==========================================================
  // Reset line synchroniser and spike filter
  // ==========================================================
  always_ff @(posedge link.pixel_clock or negedge power_reset_n)
    if (!power_reset_n)
    begin
      rs1_reg <= 1'b1;
      rs2_reg <= 1'b1;
      lp1_reg <= 1'b0;
      lp2_reg <= 1'b0;
    end
    else if (clock_enable)
    begin
      rs1_reg <= link.reset_n;
      rs2_reg <= rs1_reg;
      lp1_reg <= low_power;
      lp2_reg <= lp1_reg;
    end
  always_ff @(posedge link.pixel_clock or negedge power_reset_n)
    if (!power_reset_n)
    begin
      filt_reg <= 1'b1;
      fcnt_reg <= 16'h0;
    end
    else if (clock_enable)
    begin
      if (rs2_reg == filt_reg)
        fcnt_reg <= 16'h0;
      else if (fcnt_reg == 16'(FILTER - 1))
      begin
        filt_reg <= rs2_reg;
        fcnt_reg <= 16'h0;
      end
      else
        fcnt_reg <= fcnt_reg + 16'h1;
    end

  // ==========================================================
  // Reset, blanking and settings reload sequence
  // ==========================================================
  always_ff @(posedge link.pixel_clock or negedge power_reset_n)
    if (!power_reset_n)
    begin
      st_reg   <= RPT_RELOAD;
      tcnt_reg <= 32'h0;
      blank    <= 1'b1;
      in_reset <= 1'b1;
    end
    else if (clock_enable)
    begin
      case (st_reg)
        RPT_RUN:
          if (!filt_reg)
          begin
            st_reg   <= RPT_RESETTING;
            blank    <= 1'b1;
            in_reset <= 1'b1;
          end
        RPT_RESETTING:
          if (filt_reg)
          begin
            st_reg   <= RPT_RELOAD;
            tcnt_reg <= 32'h0;
          end
        default:
          if (!filt_reg)
            st_reg <= RPT_RESETTING;
          else if (tcnt_reg == 32'(RELOAD - 1))
          begin
            st_reg   <= RPT_RUN;
            in_reset <= 1'b0;
            blank    <= lp2_reg;
          end
          else
            tcnt_reg <= tcnt_reg + 32'h1;
      endcase
    end

  // ==========================================================
  // Pixel capture into a two-entry buffer
  // ==========================================================
  assign push = link.data_enable && st_reg == RPT_RUN && cnt_reg != 2'h2;
  assign pull = pix_valid && pix_ready;
  always_ff @(posedge link.pixel_clock)
    if (clock_enable && push)
      buf_mem[wr_reg] <= link.pixel_data;
  always_ff @(posedge link.pixel_clock or negedge power_reset_n)
    if (!power_reset_n)
    begin
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
      cnt_reg   <= 2'h0;
      pix_valid <= 1'b0;
      pix_data  <= 24'h0;
    end
    else if (clock_enable)
    begin
      if (push)
        wr_reg <= ~wr_reg;
      if (!pix_valid || pix_ready)
      begin
        pix_valid <= cnt_reg != 2'h0;
        if (cnt_reg != 2'h0)
        begin
          pix_data <= buf_mem[rd_reg];
          rd_reg   <= ~rd_reg;
        end
      end
      cnt_reg <= cnt_reg + {1'b0, push}
               - {1'b0, (!pix_valid || pix_ready) && cnt_reg != 2'h0};
    end
endmodule
`default_nettype wire

//--- logic/rpt_pkg.sv
// Types shared by both ends of the RGB panel link
`default_nettype none
package rpt_pkg;
  typedef enum logic [1:0] {RPT_SYNC, RPT_BACK, RPT_ACTIVE, RPT_FRONT}
    rpt_phase_type;
  typedef enum logic [1:0] {RPT_RUN, RPT_RESETTING, RPT_RELOAD}
    rpt_dev_state_type;
endpackage
`default_nettype wire

//--- tb/rgb_panel_timing_and_reset_test.sv
// Bench for the host and panel ends of the pixel link
`timescale 1ns/1ns
`default_nettype none
module rgb_panel_timing_and_reset_test;
  import rpt_pkg::*;
  logic        clock, reset_n, panel_reset, h_ready, cmd_ok, wake_ok;
  logic        p_valid, p_ready, blank, in_reset, de_d, collect, h_full;
  logic        blank2, in_reset2, low_power2, run2;
  logic        ce, h_valid, low_power1;
  localparam int CMD_T    = 20;
  localparam int WAKE_T   = 50;
  localparam int FILT_T   = 4;
  localparam int RELOAD_T = 10;
  logic [23:0] hd, p_data;
  logic [23:0] rx_q[$];
  int          bad_count, checked;
  rpt_link_if rpt_link_if_i ();
  rpt_link_if rpt_link_if_i2 ();
  rpt_host #(.CMD_WAIT(CMD_T), .WAKE_WAIT(WAKE_T)) rpt_host_i (
    .clock(clock), .reset_n(reset_n), .clock_enable(ce),
    .panel_reset(panel_reset), .pix_valid(h_valid), .pix_data(hd),
    .pix_ready(h_ready), .cmd_allowed(cmd_ok), .wake_allowed(wake_ok),
    .link(rpt_link_if_i));
  rpt_panel #(.FILTER(FILT_T), .RELOAD(RELOAD_T)) rpt_panel_i (
    .clock_enable(ce), .power_reset_n(reset_n), .low_power(low_power1),
    .pix_ready(p_ready), .pix_valid(p_valid), .pix_data(p_data),
    .blank(blank), .in_reset(in_reset), .link(rpt_link_if_i));
  rpt_panel #(.FILTER(FILT_T), .RELOAD(RELOAD_T)) rpt_panel_i2 (
    .clock_enable(ce), .power_reset_n(reset_n), .low_power(low_power2),
    .pix_ready(p_ready),
    .pix_valid(), .pix_data(), .blank(blank2), .in_reset(in_reset2),
    .link(rpt_link_if_i2));
  rpt_link_sva rpt_link_sva_i (.clock(clock), .host_reset_n(reset_n),
    .pixel_clock(rpt_link_if_i.pixel_clock),
    .hsync_n(rpt_link_if_i.hsync_n), .vsync_n(rpt_link_if_i.vsync_n),
    .data_enable(rpt_link_if_i.data_enable),
    .reset_n(rpt_link_if_i.reset_n));
  // ======
  // Clocks and stimulus processes
  initial
  begin
    clock = 1'b0;
    forever #25 clock = !clock;
  end
  initial
  begin
    rpt_link_if_i2.pixel_clock = 1'b0;
    forever
    begin
      #6;
      if (run2)
        rpt_link_if_i2.pixel_clock = !rpt_link_if_i2.pixel_clock;
    end
  end
  always @(posedge clock)
  begin
    if (reset_n && h_ready === 1'b1)
      hd <= #2 hd + 24'h000001;
    if (reset_n && h_ready === 1'b0)
      h_full <= 1'b1;
  end
  // Receiver stalls one pixel after each line's data ends
  always @(posedge rpt_link_if_i.pixel_clock)
  begin
    if (collect && p_valid === 1'b1 && p_ready === 1'b1)
      rx_q.push_back(p_data);
    p_ready <= #2 !(de_d && !rpt_link_if_i.data_enable);
    de_d <= rpt_link_if_i.data_enable;
  end
  // ======
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic lim(input int n, input int max);
    if (n >= max)
    begin
      bad_count++;
      end_sim();
    end
  endtask
  task automatic hold2(input logic v, input int c);
    rpt_link_if_i2.reset_n = v;
    repeat (c) @(posedge rpt_link_if_i2.pixel_clock);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ======
  // Scenarios
  task automatic t_allow(input int pre);
    int n, c, w;
    check(cmd_ok, 1'b0);
    n = 0;
    while (rpt_link_if_i.reset_n !== 1'b1 && n < 1000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    lim(n, 1000);
    check(n + pre >= 200, 1);
    c = -1;
    w = -1;
    for (n = 0; n < 70; n++)
    begin
      @(posedge clock);
      #1;
      if (cmd_ok === 1'b1 && c < 0)
        c = n;
      if (wake_ok === 1'b1 && w < 0)
        w = n;
    end
    check(c >= 18 && c <= 22, 1);
    check(w >= 48 && w <= 52, 1);
    $display("t_allow done");
  endtask
  task automatic t_stream();
    int n;
    n = 0;
    while (in_reset !== 1'b0 && n < 2000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    lim(n, 2000);
    check(blank, 1'b0);
    rx_q.delete();
    collect = 1'b1;
    n = 0;
    while (rx_q.size() < 600 && n < 40000)
    begin
      @(posedge clock);
      n++;
    end
    lim(n, 40000);
    collect = 1'b0;
    for (int i = 1; i < 600; i++)
      check(rx_q[i], rx_q[0] + i);
    check(h_full, 1'b1);
    $display("t_stream done");
  endtask
  task automatic t_spike();
    int n;
    run2 = 1'b1;
    @(posedge rpt_link_if_i2.pixel_clock);
    #1;
    for (int lp = 0; lp < 2; lp++)
    begin
      low_power2 = lp[0];
      hold2(1'b0, 2);
      hold2(1'b1, 30);
      check(in_reset2, 1'b0);
      hold2(1'b0, 12);
      check(in_reset2, 1'b1);
      check(blank2, 1'b1);
      hold2(1'b1, 2);
      hold2(1'b0, 2);
      rpt_link_if_i2.reset_n = 1'b1;
      n = 0;
      while (in_reset2 === 1'b1 && n < 100)
      begin
        @(posedge rpt_link_if_i2.pixel_clock);
        #1;
        n++;
      end
      lim(n, 100);
      check(n >= 14 && n <= 19, 1);
      check(blank2, lp[0]);
    end
    run2 = 1'b0;
    $display("t_spike done");
  endtask
  task automatic t_freeze();
    logic pc;
    @(posedge clock);
    #2 ce = 1'b0;
    pc = rpt_link_if_i.pixel_clock;
    repeat (8) @(posedge clock);
    #1;
    check(rpt_link_if_i.pixel_clock, pc);
    check(cmd_ok, 1'b1);
    #1 ce = 1'b1;
    @(posedge clock);
    #1;
    check(rpt_link_if_i.pixel_clock, !pc);
    $display("t_freeze done");
  endtask
  task automatic t_relink();
    @(posedge clock);
    #2 panel_reset = 1'b1;
    low_power1 = 1'b1;
    @(posedge clock);
    #2 panel_reset = 1'b0;
    repeat (4) @(posedge clock);
    t_allow(4);
    check(in_reset, 1'b0);
    check(blank, 1'b1);
    $display("t_relink done");
  endtask
  initial
  begin
    {panel_reset, collect, h_full, de_d, low_power2, run2} = 6'h00;
    {ce, h_valid, low_power1} = 3'h6;
    {bad_count, checked, hd, p_ready} = 0;
    rpt_link_if_i2.reset_n = 1'b1;
    rpt_link_if_i2.hsync_n = 1'b1;
    rpt_link_if_i2.vsync_n = 1'b1;
    rpt_link_if_i2.data_enable = 1'b0;
    rpt_link_if_i2.pixel_data = 24'h000000;
    reset_n = 1'b0;
    repeat (16) @(posedge clock);
    #2 reset_n = 1'b1;
    t_allow(0);
    t_stream();
    t_freeze();
    t_relink();
    t_spike();
    end_sim();
  end
endmodule
`default_nettype wire

//--- tb/rpt_link_sva.sv
// Assertions on the host to panel link wires
`timescale 1ns/1ns
`default_nettype none
module rpt_link_sva
(
  input wire logic clock,        // Host clock
  input wire logic host_reset_n, // Host reset
  input wire logic pixel_clock,  // Link clock
  input wire logic hsync_n,      // Line sync
  input wire logic vsync_n,      // Frame sync
  input wire logic data_enable,  // Pixel strobe
  input wire logic reset_n       // Link reset
);
  logic [15:0] hcnt, delo, decnt, rcnt;
  logic        hprev, hvalid;
  wire         hfall = hprev && !hsync_n;
  // ======
  // Line counters
  always_ff @(posedge pixel_clock or negedge reset_n)
    if (!reset_n)
    begin
      hprev  <= 1'b1;
      hvalid <= 1'b0;
      hcnt   <= 16'h0000;
      delo   <= 16'h0000;
      decnt  <= 16'h0000;
    end
    else
    begin
      hprev  <= hsync_n;
      hvalid <= hvalid | hfall;
      hcnt   <= hfall ? 16'h0000 : hcnt + 16'h0001;
      delo   <= data_enable ? 16'h0000 : delo + 16'h0001;
      decnt  <= (hfall ? 16'h0000 : decnt) + {15'h0000, data_enable};
    end
  // Length of each link reset pulse
  always_ff @(posedge clock or negedge host_reset_n)
    if (!host_reset_n)
      rcnt <= 16'h0000;
    else
      rcnt <= reset_n ? 16'h0000 : rcnt + 16'h0001;
  // ======
  // Properties
  chk_de_hsync: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) !hsync_n |-> !data_enable)
    else $error("data enable during line sync");
  chk_de_vsync: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) !vsync_n |-> !data_enable)
    else $error("data enable during frame sync");
  chk_hsync_width: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) $fell(hsync_n) |-> !hsync_n [*4] ##1 hsync_n)
    else $error("line sync width wrong");
  chk_back_porch: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) $rose(hsync_n) |-> !data_enable [*8])
    else $error("back porch too short");
  chk_line_length: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) $fell(hsync_n) && hvalid |-> hcnt == 16'h01f3)
    else $error("line length wrong");
  chk_front_porch: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) $fell(hsync_n) && hvalid |-> delo >= 16'h0008)
    else $error("front porch too short");
  chk_active_count: assert property (@(posedge pixel_clock)
    disable iff (!reset_n) $fell(hsync_n) && hvalid |-> decnt <= 16'h01e0)
    else $error("too many active pixels");
  chk_reset_hold: assert property (@(posedge clock)
    disable iff (!host_reset_n) $rose(reset_n) |-> rcnt >= 16'h00c8)
    else $error("link reset pulse too short");
endmodule
`default_nettype wire
